// [irqep_bank.sv]
// Interrupt enable and pending bank for interrupt numbers 0 to 31
`timescale 1ns/1ps
`include "irqep_regs.svh"
`default_nettype none

module irqep_bank
(
   input  wire logic                     clk_sys,   // 40 MHz system clock
   input  wire logic                     resetn,    // Asynchronous reset, active low
   input  wire irqep_pkg::irqep_bus_type bus,       // Register bus request
   output var  logic [31:0]              rdata_q,   // Read data, cycle after read
   input  wire irqep_pkg::irqep_vec_type irq_pin,   // Interrupt source lines
   input  wire irqep_pkg::irqep_svc_type svc,       // Core service start/done
   output var  irqep_pkg::irqep_vec_type irq_req_q, // Requests to the core
   output var  irqep_pkg::irqep_vec_type line_q,    // Source line as the core sees it
   output var  logic                     irq_q      // Summary interrupt, level
);

   // ----------------------------------------------------------------
   // Register bus decode
   // ----------------------------------------------------------------
   logic wr_en_set;
   logic wr_en_clr;
   logic wr_pd_set;
   logic wr_pd_clr;
   logic wr_in_en;
   logic wr_lp_en;
   logic wr_sts;
   logic wr_mask;
   logic [31:0] wd;

   assign wd        = bus.wdata;
   assign wr_en_set = bus.wr && (bus.addr == `IRQEP_OFS_EN_SET);
   assign wr_en_clr = bus.wr && (bus.addr == `IRQEP_OFS_EN_CLR);
   assign wr_pd_set = bus.wr && (bus.addr == `IRQEP_OFS_PEND_SET);
   assign wr_pd_clr = bus.wr && (bus.addr == `IRQEP_OFS_PEND_CLR);
   assign wr_in_en  = bus.wr && (bus.addr == `IRQEP_OFS_IN_EN);
   assign wr_lp_en  = bus.wr && (bus.addr == `IRQEP_OFS_LP_EN);
   assign wr_sts    = bus.wr && (bus.addr == `IRQEP_OFS_STATUS);
   assign wr_mask   = bus.wr && (bus.addr == `IRQEP_OFS_MASK);

   // ----------------------------------------------------------------
   // Source line synchroniser and filter
   // ----------------------------------------------------------------
   irqep_pkg::irqep_vec_type s1_q;
   irqep_pkg::irqep_vec_type s2_q;
   irqep_pkg::irqep_vec_type s3_q;
   irqep_pkg::irqep_vec_type filt_q;
   irqep_pkg::irqep_vec_type filt_d;

   // A bit changes only once the second and third stage agree
   always_comb
   begin
      filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_q   <= `IRQEP_RST_WORD;
         s2_q   <= `IRQEP_RST_WORD;
         s3_q   <= `IRQEP_RST_WORD;
         filt_q <= `IRQEP_RST_WORD;
      end
      else
      begin
         s1_q   <= irq_pin;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         filt_q <= filt_d;
      end
   end

   // ----------------------------------------------------------------
   // Enable, pending, active and line state
   // ----------------------------------------------------------------
   irqep_pkg::irqep_vec_type en_q;
   irqep_pkg::irqep_vec_type en_d;
   irqep_pkg::irqep_vec_type pend_q;
   irqep_pkg::irqep_vec_type pend_d;
   irqep_pkg::irqep_vec_type act_q;
   irqep_pkg::irqep_vec_type act_d;
   irqep_pkg::irqep_vec_type in_en_q;
   irqep_pkg::irqep_vec_type in_en_d;
   irqep_pkg::irqep_vec_type lp_en_q;
   irqep_pkg::irqep_vec_type lp_en_d;
   irqep_pkg::irqep_vec_type line_d;
   irqep_pkg::irqep_vec_type rise;
   irqep_pkg::irqep_vec_type req_d;

   always_comb
   begin
      // Disabled input with no low-power release is forced high
      line_d  = (in_en_q & filt_q) | (~in_en_q & ~lp_en_q);
      rise    = line_d & ~line_q;
      in_en_d = wr_in_en ? wd : in_en_q;
      lp_en_d = wr_lp_en ? wd : lp_en_q;

      // Only one write per cycle, so the later of set and clear always stands
      en_d = en_q;
      if (wr_en_set)
      begin
         en_d = en_q | wd;
      end
      if (wr_en_clr)
      begin
         en_d = en_q & ~wd;
      end

      pend_d = pend_q;
      if (wr_pd_set)
      begin
         pend_d = pend_q | wd;
      end
      if (wr_pd_clr)
      begin
         // Bits in service are left alone
         pend_d = pend_q & ~(wd & ~act_q);
      end
      if (svc.start)
      begin
         pend_d[svc.start_num] = 1'b0;
      end
      // A source edge in the same cycle as a clear wins
      pend_d = pend_d | rise;

      act_d = act_q;
      if (svc.done)
      begin
         act_d[svc.done_num] = 1'b0;
      end
      if (svc.start)
      begin
         act_d[svc.start_num] = 1'b1;
      end

      req_d = pend_q & en_q;
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         en_q      <= `IRQEP_RST_WORD;
         pend_q    <= `IRQEP_RST_WORD;
         act_q     <= `IRQEP_RST_WORD;
         in_en_q   <= `IRQEP_RST_WORD;
         lp_en_q   <= `IRQEP_RST_WORD;
         line_q    <= `IRQEP_RST_WORD;
         irq_req_q <= `IRQEP_RST_WORD;
      end
      else
      begin
         en_q      <= en_d;
         pend_q    <= pend_d;
         act_q     <= act_d;
         in_en_q   <= in_en_d;
         lp_en_q   <= lp_en_d;
         line_q    <= line_d;
         irq_req_q <= req_d;
      end
   end

   // ----------------------------------------------------------------
   // Event status, mask and summary interrupt
   // ----------------------------------------------------------------
   logic [2:0] sts_q;
   logic [2:0] sts_d;
   logic [2:0] mask_q;
   logic [2:0] mask_d;
   logic [2:0] evt;
   logic       irq_d;

   always_comb
   begin
      evt                   = 3'h0;
      evt[`IRQEP_EVT_PEND]  = |rise;
      evt[`IRQEP_EVT_SVC]   = svc.start;
      evt[`IRQEP_EVT_SPUR]  = |(rise & ~in_en_q);
      // Set beats a write-one-to-clear in the same cycle
      sts_d  = (sts_q & ~(wr_sts ? wd[2:0] : 3'h0)) | evt;
      mask_d = wr_mask ? wd[2:0] : mask_q;
      irq_d  = |(sts_q & mask_q);
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         sts_q  <= `IRQEP_RST_EVT;
         mask_q <= `IRQEP_RST_EVT;
         irq_q  <= 1'b0;
      end
      else
      begin
         sts_q  <= sts_d;
         mask_q <= mask_d;
         irq_q  <= irq_d;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [31:0] rdata_d;

   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (bus.rd)
      begin
         unique case (bus.addr)
            `IRQEP_OFS_EN_SET,
            `IRQEP_OFS_EN_CLR:   rdata_d = en_q;
            `IRQEP_OFS_PEND_SET,
            `IRQEP_OFS_PEND_CLR: rdata_d = pend_q;
            `IRQEP_OFS_ACTIVE:   rdata_d = act_q;
            `IRQEP_OFS_IN_EN:    rdata_d = in_en_q;
            `IRQEP_OFS_LP_EN:    rdata_d = lp_en_q;
            `IRQEP_OFS_STATUS:   rdata_d = {29'h0000_0000, sts_q};
            `IRQEP_OFS_MASK:     rdata_d = {29'h0000_0000, mask_q};
            default:             rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   en_set_a: assert property (wr_en_set |=> (en_q == ($past(en_q) | $past(wd))))
      else $error("enable set did not add exactly the written ones");

   en_read_a: assert property (bus.rd && bus.addr == `IRQEP_OFS_EN_SET |=> rdata_q == $past(en_q))
      else $error("enable read did not return the enable state");

   en_clr_a: assert property (wr_en_clr |=> (en_q & $past(wd)) == 32'h0000_0000)
      else $error("enable clear left a written bit enabled");

   pend_clr_a: assert property (wr_pd_clr |=>
      (pend_q & $past(wd) & ~$past(act_q) & ~$past(rise)) == 32'h0000_0000)
      else $error("pending clear did not clear an idle interrupt");

   act_keep_a: assert property (wr_pd_clr && !svc.done |=> (act_q & $past(act_q)) == $past(act_q))
      else $error("pending clear disturbed an interrupt in service");

   pend_read_a: assert property (bus.rd && bus.addr == `IRQEP_OFS_PEND_CLR |=> rdata_q == $past(pend_q))
      else $error("pending read did not return the pending state");

   pend_set_a: assert property (wr_pd_set && !svc.start |=> (pend_q & $past(wd)) == $past(wd))
      else $error("pending set did not set a written bit");

   spur_line_a: assert property (1'b1 |=>
      (line_q | $past(in_en_q) | $past(lp_en_q)) == 32'hFFFF_FFFF)
      else $error("disabled external input did not read high");

   req_gate_a: assert property (1'b1 |=> irq_req_q == ($past(pend_q) & $past(en_q)))
      else $error("request does not follow pending and enable");

   pend_hold_a: assert property (!wr_pd_clr && !svc.start |=> (pend_q & $past(pend_q)) == $past(pend_q))
      else $error("pending bit dropped without clear or service");

   irq_out_a: assert property (1'b1 |=> irq_q == |($past(sts_q) & $past(mask_q)))
      else $error("summary interrupt does not follow status and mask");

   req_cov_c: cover property (wr_en_set ##[1:20] |irq_req_q);
   svc_cov_c: cover property (svc.start ##[1:20] svc.done);
   spur_cov_c: cover property (sts_q[`IRQEP_EVT_SPUR] && mask_q[`IRQEP_EVT_SPUR] ##1 irq_q);
   lp_cov_c: cover property (wr_lp_en ##1 (lp_en_q != 32'h0000_0000));

endmodule

`default_nettype wire

// [irqep_regs.svh]
// Register offsets and reset values of the interrupt enable/pending bank
`ifndef IRQEP_REGS_SVH
`define IRQEP_REGS_SVH

// ----------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------
`define IRQEP_OFS_EN_SET    8'h00
`define IRQEP_OFS_EN_CLR    8'h04
`define IRQEP_OFS_PEND_SET  8'h08
`define IRQEP_OFS_PEND_CLR  8'h0C
`define IRQEP_OFS_ACTIVE    8'h10
`define IRQEP_OFS_IN_EN     8'h14
`define IRQEP_OFS_LP_EN     8'h18
`define IRQEP_OFS_STATUS    8'h1C
`define IRQEP_OFS_MASK      8'h20

// ----------------------------------------------------------------
// Status and mask bit positions
// ----------------------------------------------------------------
`define IRQEP_EVT_PEND      0
`define IRQEP_EVT_SVC       1
`define IRQEP_EVT_SPUR      2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IRQEP_RST_WORD      32'h0000_0000
`define IRQEP_RST_EVT       3'h0

`endif

// [irqep_pkg.sv]
// Types shared by the interrupt enable/pending bank
`default_nettype none

package irqep_pkg;

   localparam int NUM_IRQ = 32;
   localparam int NUM_EVT = 3;

   typedef logic [NUM_IRQ-1:0] irqep_vec_type;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } irqep_bus_type;

   typedef struct packed {
      logic       start;
      logic [4:0] start_num;
      logic       done;
      logic [4:0] done_num;
   } irqep_svc_type;

endpackage

`default_nettype wire

// [irqep_core_model.sv]
// Model of the processor core and the interrupt sources facing the bank
`timescale 1ns/1ps
`default_nettype none

module irqep_core_model
(
   input  wire logic                     clk_sys, // System clock
   input  wire irqep_pkg::irqep_vec_type irq_req, // Requests from the bank
   output var  irqep_pkg::irqep_vec_type irq_pin, // Source lines
   output var  irqep_pkg::irqep_svc_type svc      // Service start/done
);
   initial
   begin
      irq_pin = '0;
      svc     = '0;
   end

   task automatic set_pin(input int n, input logic v);
      @(posedge clk_sys);
      irq_pin[n] <= v;
   endtask

   // The core may take its time before it starts servicing; the request is
   // looked at mid-cycle, where it has settled, and start is raised on an edge
   task automatic serve(input int n, input int dly, output logic ok);
      repeat (dly) @(posedge clk_sys);
      @(negedge clk_sys);
      ok = irq_req[n];
      @(posedge clk_sys);
      svc.start     <= 1'h1;
      svc.start_num <= 5'(n);
      @(posedge clk_sys);
      svc.start     <= 1'h0;
   endtask

   task automatic finish(input int n);
      @(posedge clk_sys);
      svc.done     <= 1'h1;
      svc.done_num <= 5'(n);
      @(posedge clk_sys);
      svc.done     <= 1'h0;
   endtask
endmodule

`default_nettype wire

// [irqep_bank_tb_top.sv]
// Self-checking testbench of the interrupt enable/pending bank
`timescale 1ns/1ps
`include "irqep_regs.svh"
`default_nettype none

module irqep_bank_tb_top;
   logic                     clk_sys;
   logic                     resetn;
   irqep_pkg::irqep_bus_type bus;
   logic [31:0]              rdata_q;
   irqep_pkg::irqep_vec_type irq_pin;
   irqep_pkg::irqep_svc_type svc;
   irqep_pkg::irqep_vec_type irq_req_q;
   irqep_pkg::irqep_vec_type line_q;
   logic                     irq_q;
   logic                     ok;
   int                       failures;
   int                       checks;

   irqep_bank i_irqep_bank (.clk_sys(clk_sys), .resetn(resetn), .bus(bus), .rdata_q(rdata_q),
      .irq_pin(irq_pin), .svc(svc), .irq_req_q(irq_req_q), .line_q(line_q), .irq_q(irq_q));
   irqep_core_model i_irqep_core_model (.clk_sys(clk_sys), .irq_req(irq_req_q), .irq_pin(irq_pin),
      .svc(svc));

   initial
   begin
      clk_sys = 1'h0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      bus <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
      @(posedge clk_sys);
      bus <= '0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
      @(posedge clk_sys);
      bus <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 32'h0000_0000};
      @(posedge clk_sys);
      bus <= '0;
      #1;
      check(name, rdata_q, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic finish_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Whole run is under two hundred cycles
   initial
   begin
      repeat (3000) @(posedge clk_sys);
      failures++;
      finish_test;
   end

   initial
   begin
      failures = 0;
      checks   = 0;
      bus      = '0;
      resetn   = 1'h0;
      repeat (4) @(posedge clk_sys);
      resetn <= 1'h1;
      cyc(2);
      check("line", line_q, 32'hFFFF_FFFF);
      rd(`IRQEP_OFS_EN_SET, 32'h0000_0000, "enable");
      rd(`IRQEP_OFS_PEND_CLR, 32'hFFFF_FFFF, "pending");
      wr(`IRQEP_OFS_IN_EN, 32'hFFFF_FFFF);
      cyc(2);
      check("line", line_q, 32'h0000_0000);
      wr(`IRQEP_OFS_PEND_CLR, 32'h0000_0000);
      rd(`IRQEP_OFS_PEND_CLR, 32'hFFFF_FFFF, "pending");
      wr(`IRQEP_OFS_PEND_CLR, 32'hFFFF_FFFF);
      rd(`IRQEP_OFS_PEND_CLR, 32'h0000_0000, "pending");
      $display("test reset done");

      wr(`IRQEP_OFS_EN_SET, 32'h0000_0005);
      wr(`IRQEP_OFS_EN_SET, 32'h0000_0000);
      rd(`IRQEP_OFS_EN_SET, 32'h0000_0005, "enable");
      wr(`IRQEP_OFS_EN_CLR, 32'h0000_0001);
      wr(`IRQEP_OFS_EN_SET, 32'h0000_0001);
      rd(`IRQEP_OFS_EN_CLR, 32'h0000_0005, "enable");
      wr(`IRQEP_OFS_EN_SET, 32'h8000_0000);
      wr(`IRQEP_OFS_EN_CLR, 32'h8000_0001);
      rd(`IRQEP_OFS_EN_SET, 32'h0000_0004, "enable");
      $display("test enable done");

      i_irqep_core_model.set_pin(2, 1'h1);
      cyc(8);
      rd(`IRQEP_OFS_PEND_CLR, 32'h0000_0004, "pending");
      check("request", irq_req_q, 32'h0000_0004);
      wr(`IRQEP_OFS_PEND_SET, 32'h0000_0008);
      wr(`IRQEP_OFS_PEND_CLR, 32'h0000_0008);
      rd(`IRQEP_OFS_PEND_SET, 32'h0000_0004, "pending");
      wr(`IRQEP_OFS_PEND_CLR, 32'h0000_0008);
      wr(`IRQEP_OFS_PEND_SET, 32'h0000_0008);
      rd(`IRQEP_OFS_PEND_SET, 32'h0000_000C, "pending");
      check("request", irq_req_q, 32'h0000_0004);
      wr(`IRQEP_OFS_PEND_CLR, 32'h0000_0008);
      $display("test pending done");

      i_irqep_core_model.serve(2, 3, ok);
      check("taken", {31'h0000_0000, ok}, 32'h0000_0001);
      cyc(2);
      rd(`IRQEP_OFS_ACTIVE, 32'h0000_0004, "active");
      rd(`IRQEP_OFS_PEND_CLR, 32'h0000_0000, "pending");
      wr(`IRQEP_OFS_PEND_SET, 32'h0000_0004);
      wr(`IRQEP_OFS_PEND_CLR, 32'h0000_0004);
      rd(`IRQEP_OFS_PEND_CLR, 32'h0000_0004, "pending");
      rd(`IRQEP_OFS_ACTIVE, 32'h0000_0004, "active");
      i_irqep_core_model.finish(2);
      wr(`IRQEP_OFS_PEND_CLR, 32'h0000_0004);
      rd(`IRQEP_OFS_PEND_CLR, 32'h0000_0000, "pending");
      rd(`IRQEP_OFS_ACTIVE, 32'h0000_0000, "active");
      $display("test service done");

      wr(`IRQEP_OFS_STATUS, 32'h0000_0007);
      wr(`IRQEP_OFS_MASK, 32'h0000_0003);
      cyc(2);
      check("irq", {31'h0000_0000, irq_q}, 32'h0000_0000);
      i_irqep_core_model.serve(0, 0, ok);
      check("taken", {31'h0000_0000, ok}, 32'h0000_0000);
      cyc(3);
      check("irq", {31'h0000_0000, irq_q}, 32'h0000_0001);
      rd(`IRQEP_OFS_STATUS, 32'h0000_0002, "status");
      wr(`IRQEP_OFS_MASK, 32'h0000_0001);
      cyc(2);
      check("irq", {31'h0000_0000, irq_q}, 32'h0000_0000);
      wr(`IRQEP_OFS_MASK, 32'h0000_0002);
      cyc(2);
      check("irq", {31'h0000_0000, irq_q}, 32'h0000_0001);
      wr(`IRQEP_OFS_STATUS, 32'h0000_0002);
      cyc(2);
      check("irq", {31'h0000_0000, irq_q}, 32'h0000_0000);
      rd(8'h40, 32'h0000_0000, "unmapped");
      i_irqep_core_model.finish(0);
      $display("test interrupt done");

      // Disabling the inputs again raises every idle line and flags a spurious event
      wr(`IRQEP_OFS_MASK, 32'h0000_0004);
      wr(`IRQEP_OFS_IN_EN, 32'h0000_0000);
      cyc(2);
      check("line", line_q, 32'hFFFF_FFFF);
      check("irq", {31'h0000_0000, irq_q}, 32'h0000_0001);
      wr(`IRQEP_OFS_LP_EN, 32'hFFFF_FFFF);
      cyc(2);
      check("line", line_q, 32'h0000_0000);
      rd(`IRQEP_OFS_LP_EN, 32'hFFFF_FFFF, "lp enable");
      wr(`IRQEP_OFS_IN_EN, 32'hFFFF_FFFF);
      cyc(2);
      check("line", line_q, 32'h0000_0004);
      $display("test line done");
      finish_test;
   end
endmodule

`default_nettype wire
